/* File: logic/hcp_pkg.sv */
// shared constants and types for the hub configuration and port power block
package hcp_pkg;
    // port count and word sizes
    localparam int HCP_PORTS = 4;
    localparam int HCP_WORD_BITS = 16;
    localparam int HCP_WORDS = 3;
    // start bit, read opcode and word address 000000, sent msb first
    localparam logic [8:0] HCP_READ_CMD = 9'h180;
    localparam int HCP_CMD_BITS = 9;
    // one dummy bit plus three data words
    localparam int HCP_RD_BITS = 1 + HCP_WORDS * HCP_WORD_BITS;
    // gang bit position inside word 0
    localparam int HCP_GANG_BIT = 14;
    // timing: system clock and serial memory clock half period (least time)
    localparam int HCP_SYS_CLK_NS = 10;
    localparam int HCP_MEM_HALF_NS = 500;
    localparam int HCP_MEM_HALF_CYC = (HCP_MEM_HALF_NS + HCP_SYS_CLK_NS - 1) / HCP_SYS_CLK_NS;
    // register byte offsets
    localparam logic [7:0] HCP_OFS_CTRL = 8'h00;
    localparam logic [7:0] HCP_OFS_STATUS = 8'h04;
    localparam logic [7:0] HCP_OFS_OC_FLAGS = 8'h08;
    localparam logic [7:0] HCP_OFS_IDENT = 8'h0c;
    // reset values
    localparam logic [3:0] HCP_CTRL_RST = 4'h0;
    localparam logic [3:0] HCP_OC_RST = 4'h0;
    // synchroniser reset: overcurrent pins idle high, loader off until its strap is seen
    localparam logic [7:0] HCP_SYNC_RST = 8'hf8;
    // status field positions
    localparam int HCP_ST_DONE = 8;
    localparam int HCP_ST_GANG = 9;
    localparam int HCP_ST_BUS_POWER_SELECT = 10;
    localparam int HCP_ST_EXTDIS = 11;
    localparam int HCP_ST_FAST = 12;
    localparam int HCP_ST_BADW0 = 13;
    // ahb transfer type
    localparam logic [1:0] HCP_HTRANS_NONSEQ = 2'h2;
    // loaded configuration travels together
    typedef struct packed {
        logic gang;
        logic [15:0] vendor;
        logic [15:0] product;
    } hcp_cfg_t;
    // serial memory loader states
    typedef enum logic [2:0] {
        HCP_SETTLE,
        HCP_CMD,
        HCP_DATA,
        HCP_DONE,
        HCP_OFF
    } hcp_state_t;
endpackage

/* File: logic/hcp_config_power_ctrl.sv */
// start-up configuration loader and downstream port power control
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01: power switch pulls overcurrent input low
// RULE_02: ganged: one overcurrent powers all ports off
// RULE_03: individual: each port power/overcurrent independent
// RULE_04: four modes from bus power and gang
// RULE_05: crystal mode: straps tied low
// RULE_06: fast clock mode: straps high, oscillator
// RULE_07: disabled loader: default identity, gang pin
// RULE_08: enabled loader: pins become memory clock/data
// RULE_09: pulldowns only while loader enabled
// RULE_10: memory organised as 64 sixteen-bit words
// RULE_11: word0 gang at bit14; then vendor, product
// RULE_12: one read after reset if enabled
// RULE_13: send start 1, opcode 10, address 000000
// RULE_14: release data; dummy 0, three words msb
// RULE_15: device makes clock; memory changes on rise
// RULE_16: memory auto-increments address per word
// RULE_17: after third word, tristate clock and data
// RULE_18: memory data in/out joined by resistor
// RULE_19: loaded gang bit replaces pin input
// RULE_20: sample on falling edge; clock idles low
module hcp_config_power_ctrl import hcp_pkg::*; #(
    parameter logic [15:0] DEFAULT_VENDOR = 16'h1234, // arbitrary value
    parameter logic [15:0] DEFAULT_PRODUCT = 16'h5678 // arbitrary value
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // straps
    input wire logic EXT_CONFIG_DISABLE_IN,
    input wire logic BUS_POWER_SELECT_IN,
    input wire logic TEST_MODE_STRAP_IN,
    // port power
    input wire logic [HCP_PORTS-1:0] OVERCURRENT_N_IN,
    output logic [HCP_PORTS-1:0] PORT_POWER_ON_N_OUT,
    // serial configuration memory pins
    output logic CFG_MEM_CLOCK_OUT,
    output logic CFG_MEM_CLOCK_OE_N_OUT,
    input wire logic CFG_MEM_DATA_IN,
    output logic CFG_MEM_DATA_OUT,
    output logic CFG_MEM_DATA_OE_N_OUT,
    output logic CFG_MEM_PULLDOWN_EN_OUT,
    // clock source selection
    output logic FAST_CLOCK_SEL_OUT
);
    localparam int SYNC_W = HCP_PORTS + 4;

    // two-stage synchronisers for every pin input
    logic [SYNC_W-1:0] sync1_r; // first stage, read only by second
    logic [SYNC_W-1:0] sync2_r;
    wire [HCP_PORTS-1:0] oc_n_s = sync2_r[HCP_PORTS+3:4];
    wire ext_dis_s = sync2_r[3];
    wire bus_pwr_s = sync2_r[2];
    wire test_s = sync2_r[1];
    wire data_s = sync2_r[0];

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            // idle levels, so no false fault flag or pulldown follows reset
            sync1_r <= HCP_SYNC_RST;
            sync2_r <= HCP_SYNC_RST;
        end else begin
            sync1_r <= {OVERCURRENT_N_IN, EXT_CONFIG_DISABLE_IN, BUS_POWER_SELECT_IN,
                        TEST_MODE_STRAP_IN, CFG_MEM_DATA_IN};
            sync2_r <= sync1_r;
        end
    end

    // loader state
    hcp_state_t state_r, state_nxt;
    logic [6:0] div_r; // position within one memory clock period
    logic [5:0] bit_r; // bits done in the current phase
    logic [HCP_CMD_BITS-1:0] cmd_r; // outgoing command shifter
    logic [HCP_RD_BITS-1:0] rx_r; // incoming bits, dummy ends in the top bit
    logic done_r; // configuration load finished
    logic ext_dis_r; // strap caught after reset release
    logic [HCP_PORTS-1:0] ctrl_r; // software power requests
    logic [HCP_PORTS-1:0] oc_lat_r; // sticky overcurrent flags

    // memory clock phase events
    wire rise_evt = (div_r == 7'(HCP_MEM_HALF_CYC - 1));
    wire fall_evt = (div_r == 7'(2 * HCP_MEM_HALF_CYC - 1));
    wire clk_high = (div_r >= 7'(HCP_MEM_HALF_CYC));
    wire busy = (state_r == HCP_CMD) || (state_r == HCP_DATA);
    wire cmd_last = (state_r == HCP_CMD) && fall_evt && (bit_r == 6'(HCP_CMD_BITS - 1));
    wire rd_last = (state_r == HCP_DATA) && fall_evt && (bit_r == 6'(HCP_RD_BITS - 1));

    // received words split into the configuration carrier
    hcp_cfg_t cfg_ld;
    assign cfg_ld.gang = rx_r[2*HCP_WORD_BITS + HCP_GANG_BIT]; // [RULE_11]
    assign cfg_ld.vendor = rx_r[2*HCP_WORD_BITS-1:HCP_WORD_BITS]; // [RULE_11]
    assign cfg_ld.product = rx_r[HCP_WORD_BITS-1:0]; // [RULE_11]
    // word 0 must hold zero in bit 15 and bits 7..0
    wire bad_w0 = rx_r[3*HCP_WORD_BITS-1] || (rx_r[2*HCP_WORD_BITS+7:2*HCP_WORD_BITS] != 8'h00);

    // effective gang: pin when loader off, loaded bit once done
    wire gang_eff = ext_dis_r ? data_s : (done_r & cfg_ld.gang); // [RULE_07] [RULE_19]
    wire [15:0] vendor_eff = (ext_dis_r || !done_r) ? DEFAULT_VENDOR : cfg_ld.vendor; // [RULE_07]
    wire [15:0] product_eff = (ext_dis_r || !done_r) ? DEFAULT_PRODUCT : cfg_ld.product; // [RULE_07]

    // loader next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HCP_SETTLE: if (fall_evt) state_nxt = ext_dis_s ? HCP_OFF : HCP_CMD; // [RULE_12]
            HCP_CMD: if (cmd_last) state_nxt = HCP_DATA; // [RULE_14]
            HCP_DATA: if (rd_last) state_nxt = HCP_DONE; // [RULE_17]
            HCP_DONE: state_nxt = HCP_DONE; // one read only
            HCP_OFF: state_nxt = HCP_OFF;
        endcase
    end

    // clock divider runs free; the settle wait covers the synchronisers
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            div_r <= '0;
        end else if (fall_evt) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    // state, strap capture and bit count
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            state_r <= HCP_SETTLE;
            ext_dis_r <= 1'b1;
            bit_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == HCP_SETTLE) begin
                ext_dis_r <= ext_dis_s; // strap caught after release
            end
            if (cmd_last || rd_last) begin
                bit_r <= '0;
            end else if (busy && fall_evt) begin
                bit_r <= bit_r + 6'h01;
            end
        end
    end

    // command shifter and receive shifter
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            cmd_r <= HCP_READ_CMD;
            rx_r <= '0;
        end else begin
            if (state_r == HCP_CMD && fall_evt) begin
                cmd_r <= {cmd_r[HCP_CMD_BITS-2:0], 1'b0}; // next bit msb first [RULE_13]
            end
            if (state_r == HCP_DATA && fall_evt) begin
                // memory moved on the rise, so the falling edge sees stable data
                rx_r <= {rx_r[HCP_RD_BITS-2:0], data_s}; // [RULE_14] [RULE_20]
            end
        end
    end

    // memory pins; drivers released after the read, pulldowns stay
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            done_r <= 1'b0;
            CFG_MEM_CLOCK_OUT <= 1'b0;
            CFG_MEM_CLOCK_OE_N_OUT <= 1'b1;
            CFG_MEM_DATA_OUT <= 1'b0;
            CFG_MEM_DATA_OE_N_OUT <= 1'b1;
            CFG_MEM_PULLDOWN_EN_OUT <= 1'b0;
            FAST_CLOCK_SEL_OUT <= 1'b0;
        end else begin
            done_r <= done_r | rd_last;
            // clock high only in the upper half of each period while busy
            CFG_MEM_CLOCK_OUT <= (state_nxt == HCP_CMD || state_nxt == HCP_DATA)
                                 && !fall_evt && clk_high; // [RULE_15] [RULE_20]
            CFG_MEM_CLOCK_OE_N_OUT <= !(state_nxt == HCP_CMD || state_nxt == HCP_DATA); // [RULE_17]
            // data driven only while the command goes out
            CFG_MEM_DATA_OUT <= (state_nxt == HCP_CMD) &&
                                ((state_r == HCP_CMD && fall_evt) ? cmd_r[HCP_CMD_BITS-2]
                                                                 : cmd_r[HCP_CMD_BITS-1]); // [RULE_13]
            CFG_MEM_DATA_OE_N_OUT <= (state_nxt != HCP_CMD); // [RULE_14]
            // pulldowns follow the loader enable, not the read progress
            CFG_MEM_PULLDOWN_EN_OUT <= !ext_dis_s; // [RULE_09]
            FAST_CLOCK_SEL_OUT <= test_s; // fast input selected by strap
        end
    end

    // software power requests and sticky overcurrent flags
    wire oc_clear_wr;
    wire [3:0] oc_clear_mask;
    wire ctrl_wr;
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            ctrl_r <= HCP_CTRL_RST;
            oc_lat_r <= HCP_OC_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= HWDATA_IN[HCP_PORTS-1:0];
            end
            // a new overcurrent wins over a clear in the same cycle
            oc_lat_r <= (oc_lat_r & ~(oc_clear_wr ? oc_clear_mask : 4'h0)) | ~oc_n_s; // [RULE_01]
        end
    end

    // port power: ganged uses request 0 and any flag, else per port
    wire oc_any = |oc_lat_r;
    wire [HCP_PORTS-1:0] pwr_on = gang_eff ? {HCP_PORTS{ctrl_r[0] & ~oc_any}} // [RULE_02]
                                           : (ctrl_r & ~oc_lat_r); // [RULE_03]
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            PORT_POWER_ON_N_OUT <= {HCP_PORTS{1'b1}};
        end else begin
            PORT_POWER_ON_N_OUT <= ~pwr_on;
        end
    end

    // ahb-lite: address phase captured, write applied in data phase
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;
    wire addr_ok = HSEL_IN && HREADY_IN && (HTRANS_IN == HCP_HTRANS_NONSEQ || HTRANS_IN[1]);
    wire [7:0] ofs = HADDR_IN[7:0];
    wire rsel_valid = (HADDR_IN[31:8] == 24'h000000);
    assign ctrl_wr = wr_pend_r && (wr_ofs_r == HCP_OFS_CTRL);
    assign oc_clear_wr = wr_pend_r && (wr_ofs_r == HCP_OFS_OC_FLAGS);
    assign oc_clear_mask = HWDATA_IN[3:0];

    // status word: power state, live pins, loader and mode bits
    wire [31:0] status_w = {18'h00000, bad_w0 & done_r, test_s, ext_dis_r, !bus_pwr_s,
                            gang_eff, done_r, ~oc_n_s, pwr_on}; // [RULE_04]
    wire [31:0] rd_mux = !rsel_valid ? 32'h00000000 :
                         (ofs == HCP_OFS_CTRL) ? {28'h0000000, ctrl_r} :
                         (ofs == HCP_OFS_STATUS) ? status_w :
                         (ofs == HCP_OFS_OC_FLAGS) ? {28'h0000000, oc_lat_r} :
                         (ofs == HCP_OFS_IDENT) ? {product_eff, vendor_eff} : 32'h00000000;

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
            HRDATA_OUT <= 32'h00000000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok && HWRITE_IN && rsel_valid;
            wr_ofs_r <= ofs;
            if (addr_ok && !HWRITE_IN) begin
                HRDATA_OUT <= rd_mux;
            end
            HREADYOUT_OUT <= 1'b1; // zero wait states
            HRESP_OUT <= 1'b0; // always okay
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    chk_gang_all_off: assert property ( // [RULE_02]
        (gang_eff && oc_any) |=> (PORT_POWER_ON_N_OUT == 4'hf))
        else $error("ganged overcurrent left a port powered");
    chk_port_independent: assert property ( // [RULE_03]
        (!gang_eff && oc_lat_r[1] && !oc_lat_r[0] && ctrl_r[0]) |=>
        (PORT_POWER_ON_N_OUT[1] && !PORT_POWER_ON_N_OUT[0]))
        else $error("individual port power not independent");
    chk_clock_idle_low: assert property ( // [RULE_20]
        !busy && !$past(busy) |-> !CFG_MEM_CLOCK_OUT)
        else $error("memory clock not low while idle");
    chk_release_after_cmd: assert property ( // [RULE_14]
        cmd_last |=> ##1 CFG_MEM_DATA_OE_N_OUT [*8])
        else $error("data line driven after command");
    chk_done_tristate: assert property ( // [RULE_17]
        rd_last |=> ##1 (CFG_MEM_CLOCK_OE_N_OUT && CFG_MEM_DATA_OE_N_OUT))
        else $error("memory pins not released after read");
    chk_pulldown_follow: assert property ( // [RULE_09]
        $changed(ext_dis_s) |=> (CFG_MEM_PULLDOWN_EN_OUT == !$past(ext_dis_s)))
        else $error("pulldown enable does not follow loader enable");
    chk_default_ident: assert property ( // [RULE_07]
        ext_dis_r && (state_r == HCP_OFF) |-> (vendor_eff == DEFAULT_VENDOR) && !busy)
        else $error("disabled loader did not keep default identity");
    chk_start_bit: assert property ( // [RULE_13]
        (state_r == HCP_SETTLE) && (state_nxt == HCP_CMD) |=>
        (CFG_MEM_DATA_OUT && !CFG_MEM_DATA_OE_N_OUT && !CFG_MEM_CLOCK_OUT))
        else $error("read did not open with start bit");
    chk_single_read: assert property ( // [RULE_12]
        (state_r == HCP_DONE) |=> (state_r == HCP_DONE) && done_r)
        else $error("loader left done state");
    chk_loaded_gang: assert property ( // [RULE_19]
        done_r && !ext_dis_r |-> (gang_eff == rx_r[2*HCP_WORD_BITS + HCP_GANG_BIT]))
        else $error("loaded gang bit not in use");

    // serial link checks
    // clock rises two cycles after the rise event while busy
    chk_rise_clock_high: assert property ( // [RULE_15]
        busy && rise_evt |=> ##1 CFG_MEM_CLOCK_OUT)
        else $error("memory clock did not rise in mid period");
    // command bit holds through the whole period
    chk_cmd_bit_hold: assert property ( // [RULE_13]
        (state_r == HCP_CMD) && !fall_evt |=> $stable(CFG_MEM_DATA_OUT))
        else $error("command bit changed away from a falling edge");
    // memory owns the data line for the whole read
    chk_data_released: assert property ( // [RULE_14]
        (state_r == HCP_DATA) |-> CFG_MEM_DATA_OE_N_OUT)
        else $error("data line driven while memory sends");
    // pulldowns stay on throughout a read
    chk_pulldown_in_read: assert property ( // [RULE_09]
        busy |-> CFG_MEM_PULLDOWN_EN_OUT)
        else $error("pulldowns off during a read");

    // loader sequencing checks
    // disabled loader never drives the memory pins
    chk_off_pins_released: assert property ( // [RULE_07]
        (state_r == HCP_OFF) |->
        (CFG_MEM_CLOCK_OE_N_OUT && CFG_MEM_DATA_OE_N_OUT && !CFG_MEM_CLOCK_OUT))
        else $error("disabled loader drove a memory pin");
    // a disabled loader stays off until the next reset
    chk_off_stays: assert property ( // [RULE_12]
        (state_r == HCP_OFF) |=> (state_r == HCP_OFF) && !busy)
        else $error("disabled loader started a read");

    // power checks
    // a fault seen sets its flag whatever a clear write asks
    chk_oc_flag_set: assert property ( // [RULE_03]
        (oc_n_s != {HCP_PORTS{1'b1}}) |=> ((oc_lat_r & ~$past(oc_n_s)) == ~$past(oc_n_s)))
        else $error("overcurrent flag not set by an active fault");
    // ganged ports follow request bit 0 while no flag is set
    chk_gang_follow_req: assert property ( // [RULE_02]
        (gang_eff && !oc_any) |=> (PORT_POWER_ON_N_OUT == {HCP_PORTS{!$past(ctrl_r[0])}}))
        else $error("ganged ports did not follow request bit 0");
endmodule
`default_nettype wire

/* File: verif/hcp_mem_model.sv */
// behavioural serial configuration memory and downstream power switches
`timescale 1ns/100ps
`default_nettype none
module hcp_mem_model import hcp_pkg::*; (
    // serial memory pins as seen on the board
    input wire logic mem_clk_in,
    input wire logic dev_data_in,
    input wire logic dev_oe_n_in,
    input wire logic pulldown_in,
    // gang strap shares the data pin while the loader is off
    input wire logic strap_en_in,
    input wire logic strap_in,
    // stored words: word0, vendor, product
    input wire logic [47:0] words_in,
    output logic line_out,
    output logic [8:0] cmd_out,
    output var int rises_out,
    // port power switches
    input wire logic [3:0] fault_in,
    output logic [3:0] oc_n_out
);
    logic on_t = 1'b0; // toggled by the rising edge that starts driving
    logic off_t = 1'b0; // toggled by the release after the last bit
    wire drive = on_t ^ off_t; // memory output enabled
    logic q = 1'b0; // memory output bit
    logic last = 1'b0; // level before release, inverted to expose stale sampling
    int ph; // position inside one read sequence
    initial begin
        cmd_out = 9'h000;
        rises_out = 0;
    end
    assign ph = rises_out % 58;
    // one wire: device wins over the resistor-fed memory, else pulldown or drift
    assign line_out = strap_en_in ? strap_in : !dev_oe_n_in ? dev_data_in :
                      drive ? q : pulldown_in ? 1'b0 : ~last;
    // shift the command in, then change the output on every rising edge
    always @(posedge mem_clk_in) begin
        rises_out <= rises_out + 1;
        if (ph < 9) begin
            cmd_out <= {cmd_out[7:0], line_out};
        end else begin
            if (ph == 9) begin
                on_t <= ~off_t;
            end
            q <= (ph == 9) ? 1'b0 : words_in[57 - ph];
        end
    end
    // hold the last bit a while past the final falling edge, then let go
    always @(negedge mem_clk_in) begin
        if (ph == 0 && drive) begin
            last <= q;
            off_t <= #200 on_t;
        end
    end
    // open-drain fault outputs with board pullup
    assign oc_n_out = ~fault_in;
endmodule
`default_nettype wire

/* File: verif/hcp_config_power_ctrl_tb.sv */
// self-checking bench for the configuration loader and port power block
`timescale 1ns/100ps
`default_nettype none
module hcp_config_power_ctrl_tb import hcp_pkg::*;;
    localparam logic [31:0] DEF_ID = 32'h5678_1234; // arbitrary default identity
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic ext_dis = 1'b0, bus_pwr = 1'b0, tmode = 1'b0, gang_pin = 1'b0;
    logic [3:0] fault = 4'h0;
    logic [47:0] words = 48'h0;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, mclk, mclk_oe_n, mdo, mdo_oe_n, pd, fast, line;
    wire logic [3:0] oc_n, pwr_n;
    wire logic [8:0] cmd;
    int rises, fails = 0, checks = 0, cyc = 0, loads = 0;
    hcp_config_power_ctrl dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .EXT_CONFIG_DISABLE_IN(ext_dis),
        .BUS_POWER_SELECT_IN(bus_pwr), .TEST_MODE_STRAP_IN(tmode),
        .OVERCURRENT_N_IN(oc_n), .PORT_POWER_ON_N_OUT(pwr_n), .CFG_MEM_CLOCK_OUT(mclk),
        .CFG_MEM_CLOCK_OE_N_OUT(mclk_oe_n), .CFG_MEM_DATA_IN(line),
        .CFG_MEM_DATA_OUT(mdo), .CFG_MEM_DATA_OE_N_OUT(mdo_oe_n),
        .CFG_MEM_PULLDOWN_EN_OUT(pd), .FAST_CLOCK_SEL_OUT(fast));
    hcp_mem_model mem_u (.mem_clk_in(!mclk_oe_n & mclk), .dev_data_in(mdo),
        .dev_oe_n_in(mdo_oe_n), .pulldown_in(pd), .strap_en_in(ext_dis),
        .strap_in(gang_pin), .words_in(words), .line_out(line), .cmd_out(cmd),
        .rises_out(rises), .fault_in(fault), .oc_n_out(oc_n));
    always #5 clk = ~clk;
    // watchdog: the four runs need about 12000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single word transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= HCP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask
    // requested ports on, flagged ports off; ganged follows bit0, any flag kills all
    function automatic logic [3:0] exp_pwr_n(input logic [3:0] c, input logic [3:0] f,
                                            input logic g);
        logic [3:0] on;
        on = g ? {4{c[0]}} : c;
        on = (g && f != 4'h0) ? 4'h0 : on & ~f;
        return ~on;
    endfunction
    // one reset with straps b (bus powered, loader off) and gang g
    task automatic run_case(input logic b, input logic g);
        logic [3:0] c;
        int p;
        if (!b) loads = loads + 1;
        rst <= 1'b1;
        ext_dis <= b;
        bus_pwr <= b;
        gang_pin <= g;
        tmode <= 1'($urandom_range(0, 1));
        words <= {1'b0, g, 14'h0, 32'($urandom)};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ahb(1'b0, 32'(HCP_OFS_IDENT), 32'h0, rd);
        chk(rd, DEF_ID);
        rd = 32'h0;
        while (!b && rd[HCP_ST_DONE] !== 1'b1) ahb(1'b0, 32'(HCP_OFS_STATUS), 32'h0, rd);
        repeat (30) @(posedge clk);
        ahb(1'b0, 32'(HCP_OFS_STATUS), 32'h0, rd);
        chk(32'(rd[13:9]), 32'({1'b0, tmode, b, ~b, g}));
        ahb(1'b0, 32'(HCP_OFS_IDENT), 32'h0, rd);
        chk(rd, b ? DEF_ID : {words[15:0], words[31:16]});
        chk(32'({pd, mclk_oe_n, mdo_oe_n, mclk, mdo, hresp, fast}),
            32'({~b, 3'b110, 2'b00, tmode}));
        chk(32'(cmd), 32'(HCP_READ_CMD));
        chk(32'(rises), 32'(58 * loads));
        c = 4'($urandom) | 4'h1;
        ahb(1'b1, 32'(HCP_OFS_CTRL), 32'(c), rd);
        repeat (4) @(posedge clk);
        chk(32'(pwr_n), 32'(exp_pwr_n(c, 4'h0, g)));
        // port 1 by hand when the pin sets the mode, random otherwise
        p = b ? 1 : $urandom_range(0, 3);
        fault[p] <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(pwr_n), 32'(exp_pwr_n(c, 4'(1 << p), g)));
        ahb(1'b1, 32'(HCP_OFS_OC_FLAGS), 32'hf, rd);
        ahb(1'b0, 32'(HCP_OFS_OC_FLAGS), 32'h0, rd);
        chk(rd, 32'(1 << p));
        fault[p] <= 1'b0;
        repeat (4) @(posedge clk);
        ahb(1'b1, 32'(HCP_OFS_OC_FLAGS), 32'hf, rd);
        ahb(1'b0, 32'(HCP_OFS_OC_FLAGS), 32'h0, rd);
        chk(rd, 32'h0);
        repeat (4) @(posedge clk);
        chk(32'(pwr_n), 32'(exp_pwr_n(c, 4'h0, g)));
        ahb(1'b1, 32'h10, 32'hffff_ffff, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        chk(rd, 32'h0);
    endtask
    // all four power modes; the loader runs in the self powered ones
    initial begin
        void'($urandom(9416));
        for (int i = 0; i < 4; i++) begin
            run_case(i[1], i[0]);
        end
        summarize();
    end
endmodule
`default_nettype wire
